// File: design/gpr_pkg.sv
// package for the gpio and port routing block
// assumes a single 200 MHz clock and an apb register bus
package gpr_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DED_PINS = 8;
	localparam int unsigned ADDR_LINES = 16;
	localparam int unsigned SER_PINS = 6;
	// byte offsets
	localparam logic [7:0] OFS_DED_DIR = 8'h00;
	localparam logic [7:0] OFS_DED_DATA = 8'h04;
	localparam logic [7:0] OFS_LINE_EN = 8'h08;
	localparam logic [7:0] OFS_LINE_DIR = 8'h0c;
	localparam logic [7:0] OFS_LINE_DATA = 8'h10;
	localparam logic [7:0] OFS_BUS_SEL = 8'h14;
	// bus select field positions
	localparam int unsigned PP_MODE_LSB = 0;
	localparam int unsigned SP1_MODE_LSB = 2;
	localparam int unsigned SP2_MODE_LSB = 4;
	localparam int unsigned MEM_WIDE_BIT = 6;
	localparam int unsigned MEM_SDRAM_BIT = 7;
	localparam int unsigned BUS_SEL_W = 8;
	// reset values and ball-package pin positions
	localparam logic [7:0] DED_DIR_RESET = 8'h00;
	localparam logic [15:0] LINE_RESET = 16'h0000;
	localparam logic [7:0] BUS_SEL_RESET = 8'h41;
	localparam logic [15:0] BALL_LINES = 16'hc000;
	localparam int unsigned DED_BALL_PIN = 5;
	typedef enum logic [1:0]
	{
		PP_DATA_MEM = 2'b00,
		PP_FULL_MEM = 2'b01,
		PP_HOST_PLAIN = 2'b10,
		PP_HOST_MUX = 2'b11
	} gpr_pp_mode_t;
	typedef enum logic [1:0]
	{
		SP_BUFFERED = 2'b00,
		SP_CARD = 2'b01,
		SP_RSVD2 = 2'b10,
		SP_RSVD3 = 2'b11
	} gpr_sp_mode_t;
	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} gpr_apb_req_t;
	typedef struct packed
	{
		logic [SER_PINS-1:0] o;
		logic [SER_PINS-1:0] oe;
	} gpr_pin_drive_t;
endpackage : gpr_pkg

// File: design/gpr_serial_route.sv
// routes one six-pin serial port to the buffered serial port or card interface
// assumes both engines and pins are on core_clk; pins already synchronised
module gpr_serial_route
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [1:0] mode,
	input wire gpr_pkg::gpr_pin_drive_t bsp_drive,
	input wire gpr_pkg::gpr_pin_drive_t card_drive,
	input wire logic [gpr_pkg::SER_PINS-1:0] pin_in,
	output gpr_pkg::gpr_pin_drive_t pin_drive,
	output logic [gpr_pkg::SER_PINS-1:0] bsp_in,
	output logic [gpr_pkg::SER_PINS-1:0] card_in
);
	// reserved codes park the pins undriven rather than guess an engine
	always_ff @(posedge core_clk)
	begin
		if (reset)
			pin_drive <= '0;
		else if (mode == gpr_pkg::SP_BUFFERED)
			pin_drive <= bsp_drive; // RULE4
		else if (mode == gpr_pkg::SP_CARD)
			pin_drive <= card_drive; // RULE4
		else
			pin_drive <= '0;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			bsp_in <= '0;
			card_in <= '0;
		end
		else
		begin
			bsp_in <= (mode == gpr_pkg::SP_BUFFERED) ? pin_in : '0; // RULE4
			card_in <= (mode == gpr_pkg::SP_CARD) ? pin_in : '0; // RULE4
		end
	end

	sp_route_a: assert property (@(posedge core_clk) disable iff (reset) // RULE4
		(mode == gpr_pkg::SP_CARD) ##1 (mode == gpr_pkg::SP_CARD) |-> pin_drive == $past(card_drive))
		else $error("card routing wrong");
endmodule : gpr_serial_route

// File: design/gpr_top.sv
// gpio and port routing: dedicated pins, address-line gpio, port routing, apb regs
// assumes apb master on core_clk; pin inputs are asynchronous
//////////////////////////////////////////////////////////////////////////////
// Contract
// RULE1 - wide memory holds lowest address low
// RULE2 - wide async, wide sdram, narrow async read
// RULE3 - extra lowest pin only async memory
// RULE4 - serial mode 00 buffered, 01 card
// RULE5 - eight dedicated pins, independent directions
// RULE6 - direction 0 input, 1 output
// RULE7 - input pin data reads pin level
// RULE8 - output pin data drives level
// RULE9 - upper dedicated bits read zero
// RULE10 - reset makes dedicated pins inputs
// RULE11 - pin five only on ball package
// RULE12 - line gpio only in modes 00, 11
// RULE13 - enable 0 address, 1 gpio; code drives no address in modes 00, 11 and in mode 01 address on every available line except line 0 on the ball package
// RULE14 - line direction 0 input, 1 output
// RULE15 - line data drives outputs, reads inputs
// RULE16 - software sets enable before direction
// RULE17 - lines 15, 14 only ball package
// RULE18 - parallel mode field selects port use
// RULE19 - serial one mode field, 10/11 reserved
// RULE20 - disabled line never driven by gpio
module gpr_top
#(
	parameter bit BALL_PKG = 1'b1,
	parameter int unsigned NUM_DED = gpr_pkg::DED_PINS
)
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [gpr_pkg::ADDR_W-1:0] paddr,
	input wire logic [gpr_pkg::DATA_W-1:0] pwdata,
	output logic [gpr_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [gpr_pkg::DED_PINS-1:0] ded_pin_in,
	output logic [gpr_pkg::DED_PINS-1:0] ded_pin_out,
	output logic [gpr_pkg::DED_PINS-1:0] ded_pin_oe,
	input wire logic [gpr_pkg::ADDR_LINES-1:0] mem_addr,
	input wire logic mem_addr_valid,
	input wire logic mem_write,
	input wire logic [gpr_pkg::ADDR_LINES-1:0] line_pin_in,
	output logic [gpr_pkg::ADDR_LINES-1:0] line_pin_out,
	output logic [gpr_pkg::ADDR_LINES-1:0] line_pin_oe,
	output logic extra_low_addr_out,
	output logic extra_low_addr_oe,
	output logic mem_write_refused,
	input wire gpr_pkg::gpr_pin_drive_t sp1_bsp_drive,
	input wire gpr_pkg::gpr_pin_drive_t sp1_card_drive,
	input wire logic [gpr_pkg::SER_PINS-1:0] sp1_pin_in,
	output gpr_pkg::gpr_pin_drive_t sp1_pin_drive,
	output logic [gpr_pkg::SER_PINS-1:0] sp1_bsp_in,
	output logic [gpr_pkg::SER_PINS-1:0] sp1_card_in
);
	if (NUM_DED != gpr_pkg::DED_PINS)
	begin : g_ded_check
		$error("dedicated pin count must be eight");
	end

	//////////////////////////////////////////////////////////////////////////////
	logic [gpr_pkg::DED_PINS-1:0] ded_dir_reg, ded_out_reg, ded_avail;
	logic [gpr_pkg::DED_PINS-1:0] ded_meta_reg, ded_sync_reg;
	logic [gpr_pkg::ADDR_LINES-1:0] line_en_reg, line_dir_reg, line_data_reg;
	logic [gpr_pkg::ADDR_LINES-1:0] line_meta_reg, line_sync_reg, line_avail, line_gpio;
	logic [gpr_pkg::BUS_SEL_W-1:0] bus_sel_reg;
	logic [gpr_pkg::SER_PINS-1:0] sp_meta_reg, sp_sync_reg;
	logic [1:0] pp_mode;
	logic gpio_mode_ok, wr_en, rd_en, mapped;
	logic [gpr_pkg::DATA_W-1:0] rd_next;
	// pin five and lines 15..14 vanish on the flatpack
	always_comb
	begin
		ded_avail = '1;
		ded_avail[gpr_pkg::DED_BALL_PIN] = BALL_PKG; // RULE11
		line_avail = BALL_PKG ? '1 : ~gpr_pkg::BALL_LINES; // RULE17
	end

	assign pp_mode = bus_sel_reg[gpr_pkg::PP_MODE_LSB +: 2]; // RULE18
	assign gpio_mode_ok = (pp_mode == gpr_pkg::PP_DATA_MEM)
		|| (pp_mode == gpr_pkg::PP_HOST_MUX); // RULE12
	assign line_gpio = gpio_mode_ok ? (line_en_reg & line_avail) : '0; // RULE13 RULE12
	// map check gates the write enable and pslverr; the read case decodes paddr itself
	function automatic logic is_mapped(input logic [gpr_pkg::ADDR_W-1:0] a);
		is_mapped = (a == gpr_pkg::OFS_DED_DIR) || (a == gpr_pkg::OFS_DED_DATA)
			|| (a == gpr_pkg::OFS_LINE_EN) || (a == gpr_pkg::OFS_LINE_DIR)
			|| (a == gpr_pkg::OFS_LINE_DATA) || (a == gpr_pkg::OFS_BUS_SEL);
	endfunction : is_mapped

	//////////////////////////////////////////////////////////////////////////////
	// apb slave, zero wait states
	assign mapped = is_mapped(paddr);
	assign wr_en = psel && penable && pwrite && mapped;
	assign rd_en = psel && !penable && !pwrite;

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
		end
	end

	always_comb
	begin
		rd_next = '0;
		unique case (paddr)
			gpr_pkg::OFS_DED_DIR: rd_next[7:0] = ded_dir_reg & ded_avail; // RULE9
			gpr_pkg::OFS_DED_DATA: // RULE7 RULE9
				rd_next[7:0] = ((ded_dir_reg & ded_out_reg) | (~ded_dir_reg & ded_sync_reg))
					& ded_avail;
			gpr_pkg::OFS_LINE_EN: rd_next[15:0] = line_en_reg & line_avail;
			gpr_pkg::OFS_LINE_DIR: rd_next[15:0] = line_dir_reg & line_avail;
			gpr_pkg::OFS_LINE_DATA: // RULE15
				rd_next[15:0] = ((line_dir_reg & line_data_reg)
					| (~line_dir_reg & line_sync_reg)) & line_avail;
			gpr_pkg::OFS_BUS_SEL: rd_next[7:0] = bus_sel_reg;
			default: rd_next = '0;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			prdata <= '0;
		else if (rd_en)
			prdata <= rd_next;
	end

	//////////////////////////////////////////////////////////////////////////////
	// register writes; upper bits dropped
	always_ff @(posedge core_clk)
	begin
		if (reset)
			ded_dir_reg <= gpr_pkg::DED_DIR_RESET; // RULE10
		else if (wr_en && paddr == gpr_pkg::OFS_DED_DIR)
			ded_dir_reg <= pwdata[7:0] & ded_avail; // RULE5 RULE9 RULE11
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			ded_out_reg <= gpr_pkg::DED_DIR_RESET;
		else if (wr_en && paddr == gpr_pkg::OFS_DED_DATA)
			ded_out_reg <= pwdata[7:0] & ded_avail; // RULE8 RULE9
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			line_en_reg <= gpr_pkg::LINE_RESET;
			line_dir_reg <= gpr_pkg::LINE_RESET;
			line_data_reg <= gpr_pkg::LINE_RESET;
		end
		else if (wr_en)
		begin
			// no order enforced: software is trusted to enable first
			if (paddr == gpr_pkg::OFS_LINE_EN)
				line_en_reg <= pwdata[15:0] & line_avail; // RULE13 RULE17
			if (paddr == gpr_pkg::OFS_LINE_DIR)
				line_dir_reg <= pwdata[15:0] & line_avail; // RULE14 RULE16
			if (paddr == gpr_pkg::OFS_LINE_DATA)
				line_data_reg <= pwdata[15:0] & line_avail; // RULE15
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			bus_sel_reg <= gpr_pkg::BUS_SEL_RESET;
		else if (wr_en && paddr == gpr_pkg::OFS_BUS_SEL)
			bus_sel_reg <= pwdata[7:0]; // RULE18 RULE19
	end

	//////////////////////////////////////////////////////////////////////////////
	// two-stage synchronisers for pin inputs
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			ded_meta_reg <= '0;
			ded_sync_reg <= '0;
			line_meta_reg <= '0;
			line_sync_reg <= '0;
			sp_meta_reg <= '0;
			sp_sync_reg <= '0;
		end
		else
		begin
			ded_meta_reg <= ded_pin_in;
			ded_sync_reg <= ded_meta_reg; // RULE7 RULE10
			line_meta_reg <= line_pin_in;
			line_sync_reg <= line_meta_reg;
			sp_meta_reg <= sp1_pin_in;
			sp_sync_reg <= sp_meta_reg;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// dedicated pin drivers
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			ded_pin_out <= '0;
			ded_pin_oe <= '0; // RULE10
		end
		else
		begin
			ded_pin_out <= ded_out_reg & ded_dir_reg; // RULE8
			ded_pin_oe <= ded_dir_reg & ded_avail; // RULE6 RULE11
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// address line mux: memory address in full memory mode on every available line except line 0 on the ball package, else gpio per line
	logic wide_mem, sdram_mem, full_mem;
	logic [gpr_pkg::ADDR_LINES-1:0] addr_word;
	assign wide_mem = bus_sel_reg[gpr_pkg::MEM_WIDE_BIT];
	assign sdram_mem = bus_sel_reg[gpr_pkg::MEM_SDRAM_BIT];
	assign full_mem = (pp_mode == gpr_pkg::PP_FULL_MEM);

	always_comb
	begin
		addr_word = mem_addr;
		if (wide_mem || sdram_mem)
			addr_word[0] = 1'b0; // RULE1
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			line_pin_out <= '0;
			line_pin_oe <= '0;
		end
		else
		begin
			line_pin_out <= line_gpio & line_dir_reg & line_data_reg; // RULE15 RULE20
			line_pin_oe <= line_gpio & line_dir_reg; // RULE14 RULE20
			if (full_mem)
			begin
				line_pin_out <= addr_word & line_avail;
				line_pin_oe <= line_avail;
				// lowest line is released undriven on the ball package
				if (BALL_PKG)
				begin
					line_pin_out[0] <= 1'b0; // RULE3
					line_pin_oe[0] <= 1'b0;
				end
			end
		end
	end

	// extra lowest pin: async memory only, ball package only
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			extra_low_addr_out <= 1'b0;
			extra_low_addr_oe <= 1'b0;
		end
		else
		begin
			extra_low_addr_out <= addr_word[0] && full_mem && BALL_PKG && !sdram_mem; // RULE3
			extra_low_addr_oe <= full_mem && BALL_PKG && !sdram_mem; // RULE3 RULE1
		end
	end

	// narrow async memory is read only: writes are refused
	always_ff @(posedge core_clk)
	begin
		if (reset)
			mem_write_refused <= 1'b0;
		else
			mem_write_refused <= mem_addr_valid && mem_write && !wide_mem && !sdram_mem; // RULE2
	end

	//////////////////////////////////////////////////////////////////////////////
	gpr_serial_route u_sp1
	(
		.core_clk(core_clk),
		.reset(reset),
		.mode(bus_sel_reg[gpr_pkg::SP1_MODE_LSB +: 2]), // RULE19
		.bsp_drive(sp1_bsp_drive),
		.card_drive(sp1_card_drive),
		.pin_in(sp_sync_reg),
		.pin_drive(sp1_pin_drive),
		.bsp_in(sp1_bsp_in),
		.card_in(sp1_card_in)
	);

	//////////////////////////////////////////////////////////////////////////////
	ded_out_a: assert property (@(posedge core_clk) disable iff (reset) // RULE8
		ded_dir_reg[0] && ded_out_reg[0] |=> ded_pin_out[0] && ded_pin_oe[0])
		else $error("dedicated output not driven");
	ded_in_a: assert property (@(posedge core_clk) disable iff (reset) // RULE6
		!ded_dir_reg[3] |=> !ded_pin_oe[3])
		else $error("input pin driven");
	ded_read_a: assert property (@(posedge core_clk) disable iff (reset) // RULE7
		psel && !penable && !pwrite && paddr == gpr_pkg::OFS_DED_DATA && !ded_dir_reg[1]
		|=> prdata[1] == $past(ded_sync_reg[1]))
		else $error("input read wrong");
	upper_zero_a: assert property (@(posedge core_clk) disable iff (reset) // RULE9
		pready && !pwrite && $past(paddr) == gpr_pkg::OFS_DED_DIR |-> prdata[31:8] == '0)
		else $error("upper bits not zero");
	reset_input_a: assert property (@(posedge core_clk) // RULE10
		$past(reset) |-> ded_pin_oe == '0)
		else $error("pin driven after reset");
	line_mode_a: assert property (@(posedge core_clk) disable iff (reset) // RULE12
		pp_mode == gpr_pkg::PP_HOST_PLAIN ##1 pp_mode == gpr_pkg::PP_HOST_PLAIN
		|-> line_pin_oe == '0)
		else $error("line gpio in wrong mode");
	line_off_a: assert property (@(posedge core_clk) disable iff (reset) // RULE20
		!full_mem && !line_en_reg[2] |=> !line_pin_oe[2])
		else $error("disabled line driven");
	line_drive_a: assert property (@(posedge core_clk) disable iff (reset) // RULE15
		line_gpio[4] && line_dir_reg[4] |=> line_pin_out[4] == $past(line_data_reg[4]))
		else $error("line level wrong");
	wide_low_a: assert property (@(posedge core_clk) disable iff (reset) // RULE1
		wide_mem && full_mem |=> !extra_low_addr_out)
		else $error("lowest address not low");
	ball_only_a: assert property (@(posedge core_clk) disable iff (reset) // RULE17
		!BALL_PKG |-> line_en_reg[15:14] == 2'b00)
		else $error("ball-only line enabled");
	narrow_wr_a: assert property (@(posedge core_clk) disable iff (reset) // RULE2
		mem_addr_valid && mem_write && !wide_mem && !sdram_mem |=> mem_write_refused)
		else $error("narrow write not refused");
endmodule : gpr_top

// File: test/gpr_board_model.sv
// board side of the pins: resolves each pin from device drive and board level
// assumes oe high means the device drives; board level shows elsewhere
module gpr_board_model
(
	input wire logic [7:0] ded_out,
	input wire logic [7:0] ded_oe,
	input wire logic [7:0] ded_ext,
	input wire logic [15:0] line_out,
	input wire logic [15:0] line_oe,
	input wire logic [15:0] line_ext,
	input wire gpr_pkg::gpr_pin_drive_t sp_drive,
	input wire logic [5:0] sp_ext,
	output logic [7:0] ded_pin,
	output logic [15:0] line_pin,
	output logic [5:0] sp_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// board keeps its own level on every released pin, never the last driven one
	assign ded_pin = (ded_oe & ded_out) | (~ded_oe & ded_ext);
	assign line_pin = (line_oe & line_out) | (~line_oe & line_ext);
	assign sp_pin = (sp_drive.oe & sp_drive.o) | (~sp_drive.oe & sp_ext);
endmodule : gpr_board_model

// File: test/gpio_and_port_routing_test.sv
// self-checking bench for the gpio and port routing block
// assumes the board model resolves the pins; apb slave answers with pready
module gpio_and_port_routing_test;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed
	{
		logic rd;
		logic err;
		logic [31:0] d;
	} gpr_note_t;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] ded_in, ded_out, ded_oe;
	logic [7:0] ded_ext = 8'h00;
	logic [15:0] mem_addr = 16'h0;
	logic mem_addr_valid = 1'b0;
	logic mem_write = 1'b0;
	logic [15:0] line_in, line_out, line_oe;
	logic [15:0] line_ext = 16'h0;
	logic low_out, low_oe, refused;
	gpr_pkg::gpr_pin_drive_t sp_bsp = '0;
	gpr_pkg::gpr_pin_drive_t sp_card = '0;
	gpr_pkg::gpr_pin_drive_t sp_drv, exp_drv;
	logic [5:0] sp_ext = 6'h0;
	logic [5:0] sp_in, bsp_in, card_in, lvl;
	logic [31:0] dir, dd, en, ldir, ld;
	logic [15:0] g;
	gpr_note_t notes[$];
	gpr_note_t nt;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;

	always #2.5 core_clk = ~core_clk;

	gpr_top i_dut
	(
		.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ded_pin_in(ded_in),
		.ded_pin_out(ded_out), .ded_pin_oe(ded_oe), .mem_addr(mem_addr),
		.mem_addr_valid(mem_addr_valid), .mem_write(mem_write),
		.line_pin_in(line_in), .line_pin_out(line_out), .line_pin_oe(line_oe),
		.extra_low_addr_out(low_out), .extra_low_addr_oe(low_oe),
		.mem_write_refused(refused), .sp1_bsp_drive(sp_bsp),
		.sp1_card_drive(sp_card), .sp1_pin_in(sp_in), .sp1_pin_drive(sp_drv),
		.sp1_bsp_in(bsp_in), .sp1_card_in(card_in)
	);

	gpr_board_model i_board
	(
		.ded_out(ded_out), .ded_oe(ded_oe), .ded_ext(ded_ext), .line_out(line_out),
		.line_oe(line_oe), .line_ext(line_ext), .sp_drive(sp_drv), .sp_ext(sp_ext),
		.ded_pin(ded_in), .line_pin(line_in), .sp_pin(sp_in)
	);

	////////////////////////////////////////
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// request held until pready is sampled high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic er);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		notes.push_back('{~w, er, e});
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge core_clk);
			n++;
		end
		if (n == 20)
			chk("pready", 32'h0, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, e, 1'b0);
	endtask : rd

	// pins pass two sync flops and a register stage
	task automatic settle();
		repeat (5) @(posedge core_clk);
	endtask : settle

	always @(posedge core_clk)
		if (psel && penable && pready === 1'b1 && notes.size() > 0)
		begin
			nt = notes.pop_front();
			chk("pslverr", {31'h0, pslverr}, {31'h0, nt.err});
			if (nt.rd)
				chk("prdata", prdata, nt.d);
		end

	// a hung handshake must still reach the report
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_total++;
			wrap_up();
		end
	end

	////////////////////////////////////////
	initial
	begin
		void'($urandom(79624));
		ded_ext = 8'($urandom);
		line_ext = 16'($urandom);
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		rd(gpr_pkg::OFS_DED_DIR, 32'h0);
		rd(gpr_pkg::OFS_DED_DATA, {24'h0, ded_ext});
		rd(gpr_pkg::OFS_LINE_EN, 32'h0);
		rd(gpr_pkg::OFS_LINE_DIR, 32'h0);
		// full memory mode drives lines 15..1 with address zero; line 0 floats to board
		rd(gpr_pkg::OFS_LINE_DATA, {31'h0, line_ext[0]});
		rd(gpr_pkg::OFS_BUS_SEL, 32'h41);
		chk("ded_pin_oe", {24'h0, ded_oe}, 32'h0);
		dir = $urandom;
		dd = $urandom;
		wr(gpr_pkg::OFS_DED_DIR, dir);
		rd(gpr_pkg::OFS_DED_DIR, {24'h0, dir[7:0]});
		wr(gpr_pkg::OFS_DED_DATA, dd);
		settle();
		chk("ded_pin_oe", {24'h0, ded_oe}, {24'h0, dir[7:0]});
		chk("ded_pin_out", {24'h0, ded_out & dir[7:0]}, {24'h0, dd[7:0] & dir[7:0]});
		rd(gpr_pkg::OFS_DED_DATA, {24'h0, (dir[7:0] & dd[7:0]) | (~dir[7:0] & ded_ext)});
		apb(1'b1, 8'h20, $urandom, 32'h0, 1'b1);
		apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
		// parallel modes 00, 01, 10, 11; mode 01 address lines judged below
		for (int m = 0; m < 4; m++)
		begin
			wr(gpr_pkg::OFS_BUS_SEL, {24'h0, 6'h10, m[1:0]});
			en = $urandom;
			ldir = $urandom;
			ld = $urandom;
			wr(gpr_pkg::OFS_LINE_EN, en);
			wr(gpr_pkg::OFS_LINE_DIR, ldir);
			wr(gpr_pkg::OFS_LINE_DATA, ld);
			settle();
			g = (m == 0 || m == 3) ? en[15:0] & ldir[15:0] : 16'h0;
			if (m != 1)
			begin
				chk("line_pin_oe", {16'h0, line_oe}, {16'h0, g});
				chk("line_pin_out", {16'h0, line_out & g}, {16'h0, ld[15:0] & g});
			end
		end
		rd(gpr_pkg::OFS_LINE_EN, {16'h0, en[15:0]});
		wr(gpr_pkg::OFS_LINE_EN, 32'h0000ffff);
		settle();
		rd(gpr_pkg::OFS_LINE_DATA, {16'h0, (ldir[15:0] & ld[15:0]) | (~ldir[15:0] & line_ext)});
		wr(gpr_pkg::OFS_BUS_SEL, 32'h41);
		mem_addr <= 16'($urandom) | 16'h0001;
		mem_addr_valid <= 1'b1;
		mem_write <= 1'b1;
		settle();
		chk("extra_low", {31'h0, low_out}, 32'h0);
		chk("line0_oe", {31'h0, line_oe[0]}, 32'h0);
		chk("extra_low_oe", {31'h0, low_oe}, 32'h1);
		chk("addr_out", {16'h0, line_out & 16'hfffe}, {16'h0, mem_addr & 16'hfffe});
		chk("refused", {31'h0, refused}, 32'h0);
		wr(gpr_pkg::OFS_BUS_SEL, 32'h01);
		settle();
		chk("refused", {31'h0, refused}, 32'h1);
		chk("extra_low", {31'h0, low_out}, {31'h0, mem_addr[0]});
		chk("extra_low_oe", {31'h0, low_oe}, 32'h1);
		mem_write <= 1'b0;
		settle();
		chk("refused", {31'h0, refused}, 32'h0);
		wr(gpr_pkg::OFS_BUS_SEL, 32'h81);
		mem_write <= 1'b1;
		settle();
		chk("extra_low", {31'h0, low_out}, 32'h0);
		chk("refused", {31'h0, refused}, 32'h0);
		chk("extra_low_oe", {31'h0, low_oe}, 32'h0);
		mem_addr_valid <= 1'b0;
		mem_write <= 1'b0;
		// serial port one in all four codes
		for (int m = 0; m < 4; m++)
		begin
			wr(gpr_pkg::OFS_BUS_SEL, {24'h0, 4'h4, m[1:0], 2'b00});
			sp_bsp <= 12'($urandom);
			sp_card <= 12'($urandom);
			sp_ext <= 6'($urandom);
			settle();
			exp_drv = (m == 0) ? sp_bsp : (m == 1) ? sp_card : '0;
			lvl = (exp_drv.oe & exp_drv.o) | (~exp_drv.oe & sp_ext);
			if (m < 2)
				chk("sp1_pin_drive", {20'h0, sp_drv}, {20'h0, exp_drv});
			chk("sp1_oe", {26'h0, sp_drv.oe}, {26'h0, exp_drv.oe});
			chk("sp1_bsp_in", {26'h0, bsp_in}, {26'h0, (m == 0) ? lvl : 6'h0});
			chk("sp1_card_in", {26'h0, card_in}, {26'h0, (m == 1) ? lvl : 6'h0});
		end
		wrap_up();
	end
endmodule : gpio_and_port_routing_test
